// *** prlc_ctrl.sv ***
// Module: software reset, loopback and speed select LSB of the copper control register
`timescale 1ns/1ps
`default_nettype none

module prlc_ctrl #(
    parameter int SWRST_CYCLES = prlc_pkg::PRLC_SWRST_CYCLES // Length of reset pulse
) (
    input  wire logic                   mclk,          // 10 MHz clock
    input  wire logic                   rst,           // Async reset, active high
    input  wire prlc_pkg::prlc_bus_type bus,           // Register bus request
    output var  logic [15:0]            rdata,         // Read data, cycle after read
    input  wire prlc_pkg::prlc_mode_type mode,         // Operating mode strap
    input  wire logic                   fiber_aneg_en, // Fiber autoneg enable
    input  wire prlc_pkg::prlc_speed_type sgmii_speed, // SGMII partner speed
    input  wire logic                   col_pin,       // COL pin, asynchronous
    input  wire logic                   line_link_up,  // Raw line link status
    input  wire logic [7:0]             mac_txd,       // MAC transmit data
    input  wire logic                   mac_tx_en,     // MAC transmit enable
    input  wire logic [7:0]             line_rxd,      // Line receive data
    input  wire logic                   line_rx_dv,    // Line receive valid
    output var  logic [7:0]             mac_rxd,       // Receive data to MAC
    output var  logic                   mac_rx_dv,     // Receive valid to MAC
    output var  logic                   link_up,       // Reported link status
    output var  logic                   sm_reset,      // State machine reset
    output var  logic                   aneg_restart,  // Autoneg restart pulse
    output var  prlc_pkg::prlc_lpbk_type lpbk          // Loopback enable and speed
);
    import prlc_pkg::*;

    // Overview: one word of control bits, a small sequencer for the
    // self-clearing reset, and a mux that turns the receive path around.
    // Everything runs on mclk; the only foreign input is the COL pin.

    // Counter wide enough for the whole pulse; the plus one keeps a
    // one-cycle pulse from asking for a zero-width counter
    localparam int CW = $clog2(SWRST_CYCLES + 1);

    // ****************************************
    // Helpers
    // ****************************************
    // Both pages decode to one word; a second copy of the bits
    // could drift apart from the first
    function automatic logic is_ctrl(input logic [4:0] a);
        is_ctrl = (a == PRLC_ADDR_CTRL_COPPER) || (a == PRLC_ADDR_CTRL_FIBER);
    endfunction

    // Forced rate from the two select bits; the reserved code runs at gigabit
    function automatic prlc_speed_type decode_spd(input logic msb, input logic lsb);
        case ({msb, lsb})
            2'b00:   decode_spd = PRLC_SPD_10;
            2'b01:   decode_spd = PRLC_SPD_100;
            default: decode_spd = PRLC_SPD_1000;
        endcase
    endfunction

    // ****************************************
    // COL pin synchroniser
    // ****************************************
    // Reset to 0 matches the idle level of COL, so no false edge follows reset
    logic col_s1_q, col_s2_q, col_s3_q;

    // Two flops before use; third holds the previous sample for edge detect.
    // COL has no relation to mclk, so the first flop may go metastable and
    // feeds nothing but the second. A pulse shorter than one clock period
    // may be missed entirely: the far side must hold the pin level longer.
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            col_s1_q <= 1'b0;
            col_s2_q <= 1'b0;
            col_s3_q <= 1'b0;
        end else begin
            col_s1_q <= col_pin;
            col_s2_q <= col_s1_q;
            col_s3_q <= col_s2_q;
        end
    end

    // ****************************************
    // Control state
    // ****************************************
    // Two states: idle, or counting the reset pulse down. One-hot codes
    // keep the decode of each state to a single bit.
    typedef enum logic [1:0] {
        PRLC_ST_IDLE  = 2'b01,
        PRLC_ST_RESET = 2'b10
    } prlc_state_type;

    // Control bits with their next values; the reset bit has no flop of its
    // own, the sequencer state stands for it on both pages
    prlc_state_type state_q, state_d;
    logic [CW-1:0]  cnt_q, cnt_d;
    logic           lpbk_en_q, lpbk_en_d;
    logic           spd_lsb_q, spd_lsb_d;       // Active speed LSB
    logic           spd_lsb_pend_q, spd_lsb_pend_d;
    logic           spd_msb_q, spd_msb_d;
    logic           aneg_en_q, aneg_en_d;
    logic           pwr_down_q, pwr_down_d;
    logic [2:0]     ext_spd_q, ext_spd_d;
    // Decoded write and the start of a reset sequence
    logic           wr_ctrl, start_rst;

    // A write to either page counts; reads never disturb any state
    assign wr_ctrl = bus.wr && is_ctrl(bus.addr);

    // Next state of reset sequencer and control bits
    always_comb begin
        state_d        = state_q;
        cnt_d          = cnt_q;
        lpbk_en_d      = lpbk_en_q;
        spd_lsb_d      = spd_lsb_q;
        spd_lsb_pend_d = spd_lsb_pend_q;
        spd_msb_d      = spd_msb_q;
        aneg_en_d      = aneg_en_q;
        pwr_down_d     = pwr_down_q;
        ext_spd_d      = ext_spd_q;
        start_rst      = 1'b0;

        // A write lands on every field at once; the speed LSB only reaches its
        // pending copy and waits for the next reset before it takes effect
        if (wr_ctrl) begin
            lpbk_en_d      = bus.wdata[PRLC_BIT_LOOPBACK];
            spd_lsb_pend_d = bus.wdata[PRLC_BIT_SPEED_LSB];
            spd_msb_d      = bus.wdata[PRLC_BIT_SPEED_MSB];
            aneg_en_d      = bus.wdata[PRLC_BIT_ANEG_EN];
            pwr_down_d     = bus.wdata[PRLC_BIT_PWR_DOWN];
            // Both pages start the same reset sequencer
            start_rst      = bus.wdata[PRLC_BIT_RESET];
            // Power down to normal operation forces a reset
            if (pwr_down_q && !bus.wdata[PRLC_BIT_PWR_DOWN]) begin
                start_rst = 1'b1;
            end
        end
        if (bus.wr && bus.addr == PRLC_ADDR_EXT_CTRL) begin
            ext_spd_d = bus.wdata[PRLC_EXT_SPD_HI:PRLC_EXT_SPD_LO];
        end

        // TBI mode follows COL edges; pin edge wins over a same-cycle write
        if (mode == PRLC_MODE_TBI && col_s2_q && !col_s3_q) begin
            lpbk_en_d = 1'b1;
        end else if (mode == PRLC_MODE_TBI && !col_s2_q && col_s3_q) begin
            lpbk_en_d = 1'b0;
        end

        // A start while a pulse runs is ignored, so writing the bit again
        // cannot stretch the pulse
        case (state_q)
            PRLC_ST_IDLE: begin
                if (start_rst) begin
                    state_d   = PRLC_ST_RESET;
                    cnt_d     = CW'(SWRST_CYCLES - 1);
                    // Pending speed bit goes live as the pulse begins
                    spd_lsb_d = spd_lsb_pend_d;
                end
            end
            PRLC_ST_RESET: begin
                // Count down to zero, then hand the bit back to software
                if (cnt_q == '0) begin
                    state_d = PRLC_ST_IDLE;
                end else begin
                    cnt_d = cnt_q - CW'(1);
                end
            end
            default: begin
                state_d = PRLC_ST_IDLE;
            end
        endcase
    end

    // Register the control state
    // Hardware reset gives the defaults; a software reset leaves the register
    // contents alone, makes the pending speed LSB live and pulses sm_reset and aneg_restart
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_q        <= PRLC_ST_IDLE;
            cnt_q          <= '0;
            lpbk_en_q      <= PRLC_RST_LOOPBACK;
            spd_lsb_q      <= PRLC_RST_SPEED_LSB;
            spd_lsb_pend_q <= PRLC_RST_SPEED_LSB;
            spd_msb_q      <= PRLC_RST_SPEED_MSB;
            aneg_en_q      <= PRLC_RST_ANEG_EN;
            pwr_down_q     <= 1'b0;
            ext_spd_q      <= PRLC_RST_EXT_SPD;
        end else begin
            state_q        <= state_d;
            cnt_q          <= cnt_d;
            lpbk_en_q      <= lpbk_en_d;
            spd_lsb_q      <= spd_lsb_d;
            spd_lsb_pend_q <= spd_lsb_pend_d;
            spd_msb_q      <= spd_msb_d;
            aneg_en_q      <= aneg_en_d;
            pwr_down_q     <= pwr_down_d;
            ext_spd_q      <= ext_spd_d;
        end
    end

    // ****************************************
    // Loopback speed selection
    // ****************************************
    // The rate is worked out all the time, not only in loopback, so the
    // status word always shows what loopback would use
    prlc_speed_type spd_sel;
    prlc_speed_type ext_spd_dec;

    // Extended field: codes 6 and 7 gigabit, 5 is 100, the rest 10;
    // code 4 is not gigabit even though its top bit is set
    always_comb begin
        case (ext_spd_q)
            3'h6, 3'h7: ext_spd_dec = PRLC_SPD_1000;
            3'h5:       ext_spd_dec = PRLC_SPD_100;
            default:    ext_spd_dec = PRLC_SPD_10;
        endcase
    end

    // Mode decides which source sets the loopback rate
    // Mode is a strap and is expected to be static while traffic flows
    always_comb begin
        case (mode)
            PRLC_MODE_COPPER: begin
                spd_sel = aneg_en_q ? ext_spd_dec
                                    : decode_spd(spd_msb_q, spd_lsb_q);
            end
            PRLC_MODE_MII_FIBER: spd_sel = PRLC_SPD_1000;
            PRLC_MODE_SGMII_MII: spd_sel = fiber_aneg_en ? sgmii_speed
                                                         : ext_spd_dec;
            // TBI has no rate of its own here and loops back at gigabit
            default:             spd_sel = PRLC_SPD_1000;
        endcase
    end

    // ****************************************
    // Readback and outputs
    // ****************************************
    // Read word, registered at the next edge
    logic [15:0] rdata_d;

    // Unmapped addresses and cycles without a read strobe give zero, so the
    // read data stand only in the cycle after the strobe
    // Reset bit reads 1 while the sequence runs, so software can poll it
    always_comb begin
        rdata_d = 16'h0000;
        if (bus.rd) begin
            case (bus.addr)
                PRLC_ADDR_CTRL_COPPER, PRLC_ADDR_CTRL_FIBER: begin
                    rdata_d[PRLC_BIT_RESET]     = (state_q == PRLC_ST_RESET);
                    rdata_d[PRLC_BIT_LOOPBACK]  = lpbk_en_q;
                    rdata_d[PRLC_BIT_SPEED_LSB] = spd_lsb_pend_q;
                    rdata_d[PRLC_BIT_ANEG_EN]   = aneg_en_q;
                    rdata_d[PRLC_BIT_PWR_DOWN]  = pwr_down_q;
                    rdata_d[PRLC_BIT_SPEED_MSB] = spd_msb_q;
                end
                PRLC_ADDR_EXT_CTRL: begin
                    rdata_d[PRLC_EXT_SPD_HI:PRLC_EXT_SPD_LO] = ext_spd_q;
                end
                // Link is masked here as on the pin, so polls and pin agree
                PRLC_ADDR_STATUS: begin
                    rdata_d[1:0] = spd_sel;
                    rdata_d[2]   = line_link_up && !lpbk_en_q;
                end
                default: rdata_d = 16'h0000;
            endcase
        end
    end

    // All outputs straight from flops
    // Trade-off: each output costs a cycle, so looped data reach the MAC one
    // cycle after they leave it; in exchange no output glitches
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rdata        <= 16'h0000;
            mac_rxd      <= 8'h00;
            mac_rx_dv    <= 1'b0;
            link_up      <= 1'b0;
            sm_reset     <= 1'b0;
            aneg_restart <= 1'b0;
            lpbk         <= '{enable: 1'b0, speed: PRLC_SPD_10};
        end else begin
            rdata        <= rdata_d;
            mac_rxd      <= lpbk_en_q ? mac_txd : line_rxd;
            mac_rx_dv    <= lpbk_en_q ? mac_tx_en : line_rx_dv;
            link_up      <= line_link_up && !lpbk_en_q;
            sm_reset     <= (state_d == PRLC_ST_RESET);
            aneg_restart <= start_rst && (state_q == PRLC_ST_IDLE);
            lpbk         <= '{enable: lpbk_en_q, speed: spd_sel};
        end
    end

endmodule // prlc_ctrl

`default_nettype wire

// *** prlc_pkg.sv ***
// Package: register layout, modes and timing constants for the reset and loopback control block
package prlc_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [4:0] PRLC_ADDR_CTRL_COPPER = 5'h00; // Copper control register
    localparam logic [4:0] PRLC_ADDR_CTRL_FIBER  = 5'h01; // Fiber-page control alias
    localparam logic [4:0] PRLC_ADDR_EXT_CTRL    = 5'h14; // Extended control (speed field)
    localparam logic [4:0] PRLC_ADDR_STATUS      = 5'h18; // Block status

    // ****************************************
    // Field positions
    // ****************************************
    localparam int PRLC_BIT_RESET     = 15;
    localparam int PRLC_BIT_LOOPBACK  = 14;
    localparam int PRLC_BIT_SPEED_LSB = 13;
    localparam int PRLC_BIT_ANEG_EN   = 12;
    localparam int PRLC_BIT_PWR_DOWN  = 11;
    localparam int PRLC_BIT_SPEED_MSB = 6;
    localparam int PRLC_EXT_SPD_HI    = 6;
    localparam int PRLC_EXT_SPD_LO    = 4;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic       PRLC_RST_RESET     = 1'h0;
    localparam logic       PRLC_RST_LOOPBACK  = 1'h0;
    localparam logic       PRLC_RST_SPEED_LSB = 1'h0;
    localparam logic       PRLC_RST_SPEED_MSB = 1'h1;
    localparam logic       PRLC_RST_ANEG_EN   = 1'h1;
    localparam logic [2:0] PRLC_RST_EXT_SPD   = 3'h6;

    // ****************************************
    // Timing
    // ****************************************
    localparam int PRLC_CLK_MHZ      = 10;
    localparam int PRLC_SWRST_NS     = 1000; // Length of the state machine reset
    localparam int PRLC_SWRST_CYCLES = (PRLC_SWRST_NS * PRLC_CLK_MHZ + 999) / 1000;

    // ****************************************
    // Modes and speeds
    // ****************************************
    typedef enum logic [1:0] {
        PRLC_MODE_COPPER     = 2'h0, // MAC to copper line
        PRLC_MODE_MII_FIBER  = 2'h1, // GMII or RGMII MAC to fiber
        PRLC_MODE_SGMII_MII  = 2'h2, // SGMII line to GMII or RGMII MAC
        PRLC_MODE_TBI        = 2'h3  // Ten-bit interface
    } prlc_mode_type;

    typedef enum logic [1:0] {
        PRLC_SPD_10   = 2'h0,
        PRLC_SPD_100  = 2'h1,
        PRLC_SPD_1000 = 2'h2
    } prlc_speed_type;

    // Loopback steering handed to the datapath
    typedef struct packed {
        logic           enable;
        prlc_speed_type speed;
    } prlc_lpbk_type;

    // Register bus request
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [4:0]  addr;
        logic [15:0] wdata;
    } prlc_bus_type;

endpackage : prlc_pkg

// *** prlc_chk.sv ***
// Checker: port properties of the reset and loopback control block
`timescale 1ns/1ps
`default_nettype none
module prlc_chk #(
    parameter int SWRST_CYCLES = 10 // Reset pulse length
) (
    input wire logic                    mclk,         // Clock
    input wire logic                    rst,          // Async reset
    input wire prlc_pkg::prlc_bus_type  bus,          // Register request
    input wire logic [15:0]             rdata,        // Read data
    input wire prlc_pkg::prlc_mode_type mode,         // Mode strap
    input wire logic                    col_pin,      // COL pin
    input wire logic [7:0]              mac_txd,      // MAC data in
    input wire logic                    mac_tx_en,    // MAC enable in
    input wire logic [7:0]              mac_rxd,      // Data to MAC
    input wire logic                    mac_rx_dv,    // Valid to MAC
    input wire logic                    link_up,      // Link status
    input wire logic                    sm_reset,     // Reset pulse
    input wire logic                    aneg_restart, // Autoneg restart
    input wire prlc_pkg::prlc_lpbk_type lpbk          // Loopback steering
);
    import prlc_pkg::*;
    // ********************
    // Properties
    // ********************
    logic [7:0] run_q;
    logic [7:0] run_d;
    logic       ctl_wr;
    // Pulse length so far; zero between pulses
    always_comb run_d = sm_reset ? run_q + 8'h01 : 8'h00;
    always_ff @(posedge mclk or posedge rst)
        if (rst) run_q <= 8'h00;
        else run_q <= run_d;
    // Addresses 0 and 1 are the two pages of one control word
    assign ctl_wr = bus.wr && bus.addr[4:1] == 4'h0;
    default clocking dcb @(posedge mclk); endclocking
    default disable iff (rst);
    swrst_start_a: assert property (ctl_wr && bus.wdata[15] && !sm_reset |=> sm_reset)
        else $error("Reset pulse missing after write");
    swrst_len_a: assert property ($fell(sm_reset) |-> run_q == 8'(SWRST_CYCLES))
        else $error("Reset pulse length wrong");
    aneg_pulse_a: assert property (aneg_restart == $rose(sm_reset))
        else $error("Autoneg restart not tied to pulse start");
    busy_read_a: assert property (bus.rd && bus.addr[4:1] == 4'h0 |=> rdata[15] == $past(sm_reset))
        else $error("Busy bit read differs from pulse");
    link_drop_a: assert property (lpbk.enable && $past(lpbk.enable) |-> !link_up)
        else $error("Link up during loopback");
    loop_data_a: assert property (lpbk.enable && $past(lpbk.enable)
        |-> {mac_rx_dv, mac_rxd} == $past({mac_tx_en, mac_txd})) else $error("Loop data wrong");
    gig_rate_a: assert property (mode == PRLC_MODE_MII_FIBER && $past(mode, 2) == mode
        && $stable(mode) && lpbk.enable |-> lpbk.speed == PRLC_SPD_1000) else $error("Fiber speed");
    col_set_a: assert property (mode == PRLC_MODE_TBI && $rose(col_pin) |-> ##[1:8] lpbk.enable)
        else $error("COL edge did not set loopback");
    cover property ($rose(sm_reset));
    cover property ($rose(lpbk.enable) && mode == PRLC_MODE_TBI);
    cover property (lpbk.enable && lpbk.speed == PRLC_SPD_100);
endmodule // prlc_chk
bind prlc_ctrl prlc_chk #(.SWRST_CYCLES(SWRST_CYCLES)) i_chk (.mclk, .rst, .bus, .rdata, .mode,
    .col_pin, .mac_txd, .mac_tx_en, .mac_rxd, .mac_rx_dv, .link_up, .sm_reset, .aneg_restart, .lpbk);
`default_nettype wire

// *** prlc_mac.sv ***
// MAC model: transmit stream that changes every cycle
`timescale 1ns/1ps
`default_nettype none
module prlc_mac (
    input  wire logic       mclk,     // Clock
    input  wire logic       rst,      // Async reset
    output var  logic [7:0] mac_txd,  // Transmit data
    output var  logic       mac_tx_en // Transmit enable
);
    // ********************
    // Transmit stream
    // ********************
    // Bytes move every cycle, in and out of frames, so a stale byte never matches
    always_ff @(posedge mclk or posedge rst)
        if (rst) {mac_tx_en, mac_txd} <= 9'h000;
        else {mac_tx_en, mac_txd} <= {mac_txd[6], mac_txd + 8'h3B};
endmodule // prlc_mac
`default_nettype wire

// *** prlc_tb.sv ***
// Testbench: register access, reset and loopback scenarios
`timescale 1ns/1ps
`default_nettype none
module tb;
    import prlc_pkg::*;
    // ********************
    // Signals and tasks
    // ********************
    localparam int SWRST = 4; // Short pulse keeps the run brief
    prlc_bus_type   bus = '0;
    prlc_mode_type  mode = PRLC_MODE_COPPER;
    prlc_speed_type sgmii_speed = PRLC_SPD_10;
    prlc_lpbk_type  lpbk;
    logic [15:0]    rdata, v;
    logic [7:0]     mac_txd, mac_rxd;
    logic [8:0]     line_q = 9'h000;
    logic           rst = 1'b1;
    logic           fiber_aneg_en = 1'b1;
    logic           col_pin = 1'b0;
    logic           line_link_up = 1'b1;
    logic           mclk, mac_tx_en, mac_rx_dv, link_up, sm_reset, aneg_restart;
    int             errors = 0;
    int             checks = 0;
    prlc_ctrl #(.SWRST_CYCLES(SWRST)) i_dut (.mclk, .rst, .bus, .rdata, .mode, .fiber_aneg_en,
        .sgmii_speed, .col_pin, .line_link_up, .mac_txd, .mac_tx_en, .line_rxd(line_q[7:0]),
        .line_rx_dv(line_q[8]), .mac_rxd, .mac_rx_dv, .link_up, .sm_reset, .aneg_restart, .lpbk);
    prlc_mac i_mac (.mclk, .rst, .mac_txd, .mac_tx_en);
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // Line stream keeps moving so the normal receive path carries traffic
    always @(posedge mclk) line_q <= {~line_q[8], line_q[7:0] + 8'h11};
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // An idle cycle follows every strobe so two strobes never share an edge
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge mclk) bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge mclk) bus <= '0;
    endtask
    task automatic peek(input logic [4:0] a);
        @(posedge mclk) bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge mclk) bus <= '0;
        #1 v = rdata;
    endtask
    task automatic rd(input logic [4:0] a, input logic [15:0] m, input logic [15:0] e, string nm);
        peek(a);
        chk(nm, e, v & m);
    endtask
    // Busy bit must read 0 before loopback is touched
    task automatic settle();
        repeat (20) begin
            peek(PRLC_ADDR_CTRL_COPPER);
            if (v[15] === 1'b0) return;
        end
        chk("busy", 16'h0000, v & 16'h8000);
    endtask
    task automatic swrst(input logic [4:0] a, input logic [15:0] d);
        wr(a, d);
        #1 chk("start", 16'h0003, {14'h0000, sm_reset, aneg_restart});
    endtask
    // Status holds link in bit 2 and speed below; link must be down in loopback
    task automatic spdchk(input prlc_speed_type e);
        rd(PRLC_ADDR_STATUS, 16'h0007, {14'h0000, e}, "status");
        chk("lpbk", {13'h0000, 1'b1, e}, {13'h0000, lpbk});
        chk("link off", 16'h0000, {15'h0000, link_up});
    endtask
    function automatic prlc_speed_type ext_spd(input int s);
        return s > 5 ? PRLC_SPD_1000 : (s == 5 ? PRLC_SPD_100 : PRLC_SPD_10);
    endfunction
    task automatic give_verdict();
        $display("Checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Run takes about two hundred cycles; a hundred times that means a hang
    initial begin
        repeat (20000) @(posedge mclk);
        errors++;
        give_verdict();
    end
    initial begin
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        rd(PRLC_ADDR_CTRL_COPPER, 16'hF840, 16'h1040, "ctrl");
        rd(PRLC_ADDR_EXT_CTRL, 16'h0070, 16'h0060, "ext");
        wr(5'h07, 16'hFFFF);
        rd(5'h07, 16'hFFFF, 16'h0000, "hole");
        $display("Test reset values done");
        for (int p = 0; p < 2; p++) begin
            swrst(5'(p), 16'h9040);
            rd(5'(1 - p), 16'h8000, 16'h8000, "alias");
            settle();
        end
        wr(PRLC_ADDR_CTRL_COPPER, 16'h1840);
        swrst(PRLC_ADDR_CTRL_COPPER, 16'h1040);
        settle();
        $display("Test software reset done");
        wr(PRLC_ADDR_CTRL_COPPER, 16'h5040);
        for (int s = 0; s < 8; s++) begin
            wr(PRLC_ADDR_EXT_CTRL, {9'h000, 3'(s), 4'h0});
            spdchk(ext_spd(s));
        end
        for (int c = 0; c < 4; c++) begin
            swrst(PRLC_ADDR_CTRL_COPPER, {2'b10, c[0], 6'h00, c[1], 6'h00});
            settle();
            wr(PRLC_ADDR_CTRL_COPPER, {2'b01, c[0], 6'h00, c[1], 6'h00});
            spdchk(c == 0 ? PRLC_SPD_10 : (c == 1 ? PRLC_SPD_100 : PRLC_SPD_1000));
        end
        swrst(PRLC_ADDR_CTRL_COPPER, 16'hA000);
        settle();
        wr(PRLC_ADDR_CTRL_COPPER, 16'h4000);
        spdchk(PRLC_SPD_100);
        swrst(PRLC_ADDR_CTRL_COPPER, 16'h8000);
        settle();
        wr(PRLC_ADDR_CTRL_COPPER, 16'h4000);
        spdchk(PRLC_SPD_10);
        @(posedge mclk) mode <= PRLC_MODE_MII_FIBER;
        spdchk(PRLC_SPD_1000);
        @(posedge mclk) mode <= PRLC_MODE_SGMII_MII;
        for (int s = 0; s < 3; s++) begin
            @(posedge mclk) sgmii_speed <= prlc_speed_type'(s);
            spdchk(prlc_speed_type'(s));
        end
        wr(PRLC_ADDR_EXT_CTRL, 16'h0050);
        @(posedge mclk) fiber_aneg_en <= 1'b0;
        spdchk(PRLC_SPD_100);
        $display("Test loopback speed done");
        @(posedge mclk) mode <= PRLC_MODE_COPPER;
        wr(PRLC_ADDR_CTRL_COPPER, 16'h1040);
        rd(PRLC_ADDR_STATUS, 16'h0004, 16'h0004, "link");
        chk("link_up", 16'h0001, {15'h0000, link_up});
        chk("rx", {7'h00, ~line_q[8], line_q[7:0] - 8'h11}, {7'h00, mac_rx_dv, mac_rxd});
        @(posedge mclk) mode <= PRLC_MODE_TBI;
        @(posedge mclk) col_pin <= 1'b1;
        repeat (8) @(posedge mclk);
        rd(PRLC_ADDR_CTRL_COPPER, 16'h4000, 16'h4000, "col rise");
        @(posedge mclk) col_pin <= 1'b0;
        repeat (8) @(posedge mclk);
        rd(PRLC_ADDR_CTRL_COPPER, 16'h4000, 16'h0000, "col fall");
        $display("Test link and pin done");
        give_verdict();
    end
endmodule // tb
`default_nettype wire
